//--- ilc_chk_props.sv
module ilc_chk (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire link_up,
  input wire aneg_fault,
  input wire style_strap,
  input wire indicator_out_a,
  input wire indicator_out_b
);
  reg [2:0] ctrl_q;
  reg [7:0] func_q;
  reg puls_q;
  reg [2:0] age_q;
  wire wr_done = psel && penable && pready && pwrite;
  wire enh_on = !ctrl_q[0] && !ctrl_q[2] && !puls_q;
  wire mapped = (paddr == 8'h00) || (paddr == 8'h04) || (paddr == 8'h08) || (paddr == 8'h0c);

  // Shadow of the control fields, updated at the same edge as the slave
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= 3'h1;
      func_q <= 8'h00;
      puls_q <= 1'b0;
      age_q <= 3'h0;
    end else begin
      age_q <= {age_q[1:0], 1'b1}; // Style latch settles after the first edges
      if (wr_done && paddr == 8'h00) ctrl_q <= pwdata[2:0];
      if (wr_done && paddr == 8'h04) func_q <= pwdata[7:0];
      if (wr_done && paddr == 8'h08) puls_q <= pwdata[12];
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready not one cycle after access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_unmapped: assert property (psel && penable && !pready && !mapped |=> pready && pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_err_only_unmapped: assert property (psel && penable && !pready && mapped |=> !pslverr)
    else $error("error on mapped access");
  a_pdn_forces_off: assert property (ctrl_q[2] |=> indicator_out_a && indicator_out_b)
    else $error("power-down did not force off");
  a_iso_forces_off: assert property (ctrl_q[0] && ctrl_q[1] |=> indicator_out_a && indicator_out_b)
    else $error("isolate did not force off");
  a_tri_no_link: assert property (age_q[2] && ctrl_q == 3'h1 && !style_strap && !link_up
    |=> indicator_out_a && indicator_out_b)
    else $error("tri-colour no link not off");
  a_force_on_low: assert property (enh_on && func_q[3:0] == 4'hf |=> !indicator_out_a)
    else $error("force on not driven low");
  a_force_off_high: assert property (!ctrl_q[0] && func_q[7:4] == 4'he |=> indicator_out_b)
    else $error("force off not driven high");
  a_aneg_shown: assert property (enh_on && func_q[3:0] == 4'hc |=> indicator_out_a == !$past(aneg_fault))
    else $error("fault code mismatch");
  a_reserved_off: assert property (!ctrl_q[0] && (func_q[7:4] == 4'h7 || func_q[7:4] == 4'hb
    || func_q[7:4] == 4'hd) |=> indicator_out_b)
    else $error("reserved code not off");
endmodule

bind ilc_indicator_ctrl ilc_chk ilc_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .link_up(link_up), .aneg_fault(aneg_fault),
  .style_strap(style_strap), .indicator_out_a(indicator_out_a), .indicator_out_b(indicator_out_b));

//--- ilc_defines.vh
`ifndef ILC_DEFINES_VH
`define ILC_DEFINES_VH

// Register byte offsets
`define ILC_OFF_CTRL 8'h00
`define ILC_OFF_FUNC 8'h04
`define ILC_OFF_BEHAV 8'h08
`define ILC_OFF_STAT 8'h0c

// Control register fields
`define ILC_CTRL_LEGACY 0
`define ILC_CTRL_ISO 1
`define ILC_CTRL_PDN 2
`define ILC_CTRL_RST 3'h1

// Function select fields and reset value
`define ILC_FUNC_A_LSB 0
`define ILC_FUNC_B_LSB 4
`define ILC_FUNC_RST 8'h00

// Behaviour register fields
`define ILC_BEH_CDIS_LSB 0
`define ILC_BEH_STR_LSB 2
`define ILC_BEH_RATE_A_LSB 4
`define ILC_BEH_RATE_B_LSB 6
`define ILC_BEH_TXONLY 8
`define ILC_BEH_PULSING 12
`define ILC_BEH_APPLY 15
`define ILC_BEH_RST 16'h0000

// Function codes
`define ILC_FN_LINK_ANY 4'h0
`define ILC_FN_LINK_1000 4'h1
`define ILC_FN_LINK_100 4'h2
`define ILC_FN_LINK_10 4'h3
`define ILC_FN_LINK_100_1000 4'h4
`define ILC_FN_LINK_10_1000 4'h5
`define ILC_FN_LINK_10_100 4'h6
`define ILC_FN_DUPLEX 4'h8
`define ILC_FN_COLLISION 4'h9
`define ILC_FN_ACTIVITY 4'ha
`define ILC_FN_ANEG_FAULT 4'hc
`define ILC_FN_FORCE_OFF 4'he
`define ILC_FN_FORCE_ON 4'hf

// Speed encoding of the status input
`define ILC_SPD_10 2'h0
`define ILC_SPD_100 2'h1
`define ILC_SPD_1000 2'h2

// Timing: core clock, timebase tick, shaping lengths in milliseconds
`define ILC_CLK_HZ 10000000
`define ILC_TICK_US 5000
`define ILC_BLINK_HALF_MS 200
`define ILC_STRETCH_MS 50
`define ILC_PULSE_HZ 5000
`define ILC_PULSE_ON_PCT 20

`endif

//--- ilc_indicator_ctrl.v
// Functional notes
// - Style from legacy select bit and style strap; the strap is latched after reset.
// - Tri-colour style forces both outputs off while port isolate is set.
// - Power-down forces both outputs off in every style.
// - Tri-colour: no link both high; 1000 low b, 100 low a, 10 both.
// - Tri-colour: asserted outputs toggle with activity; both together at 10.
// - Legacy select clear gives enhanced style with per-output four-bit function.
// - Code 0: on with any link, briefly off on activity.
// - Codes 1 to 6: like code 0, link qualified by speed set.
// - Code 8: on for full duplex; half duplex collisions turn it on.
// - Code 9: off, turned on by shaped collision events.
// - Code 10: shaped activity; transmit only when activity select bit set.
// - Code 12 shows auto-negotiation fault; 7, 11, 13 reserved and off.
// - Code 14 forces off, code 15 forces on.
// - Combine-disable bit per output, taken on a write with the apply bit, shows primary only, hides activity.
// - Stretch enable bit per output picks blink or pulse stretch.
// - Blink is 50 percent duty; single event shows half a period.
// - Stretch holds one period; lingers half to one and a half after.
// - Stretch idles at least half a period before a new event.
// - Rate field: blink 2.5/5/10/20 Hz or stretch 50/100/200/400 ms.
// - Pulsing enable modulates asserted outputs at 5 kHz, 20 percent.
// - Both transmit and receive frames count as activity.
`include "ilc_defines.vh"

module ilc_indicator_ctrl #(
  parameter TICK_CYCLES = `ILC_CLK_HZ / 1000000 * `ILC_TICK_US
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire link_up,
  input wire [1:0] link_speed,
  input wire full_duplex,
  input wire rx_activity,
  input wire tx_activity,
  input wire collision,
  input wire aneg_fault,
  input wire style_strap,
  output reg indicator_out_a,
  output reg indicator_out_b
);

  // Carrier lengths in core clocks, cut to the counter width on purpose
  localparam integer PULSE_PERIOD_I = `ILC_CLK_HZ / `ILC_PULSE_HZ;
  localparam integer PULSE_ON_I = `ILC_CLK_HZ / `ILC_PULSE_HZ * `ILC_PULSE_ON_PCT / 100;
  localparam [11:0] PULSE_CYCLES = PULSE_PERIOD_I[11:0];
  localparam [11:0] PULSE_ON_CYCLES = PULSE_ON_I[11:0];

  reg [2:0] ctrl_q;
  reg [7:0] func_q;
  reg [15:0] behav_q;
  reg [1:0] cdis_eff_q;
  reg strap_m_q;
  reg strap_s_q;
  reg [1:0] lat_age_q;
  reg strap_lat_q;
  reg [23:0] tick_cnt_q;
  reg tick_q;
  reg [11:0] pulse_cnt_q;
  reg pulse_on_q;

  wire wr_en;
  wire legacy;
  wire [1:0] shaped;
  reg [1:0] ev;
  reg [1:0] on_d;
  reg [1:0] str_en;
  reg [3:0] rate_sel;
  reg [31:0] rd_d;
  reg hit;
  wire [31:0] status_word;
  wire sel_ctrl;
  wire sel_func;
  wire sel_behav;
  wire [1:0] str_cfg;
  wire [3:0] rate_cfg;
  wire pulsing_en;

  // A request is served once pready has been seen high with the strobes
  assign wr_en = psel && penable && pready && pwrite;
  assign legacy = ctrl_q[`ILC_CTRL_LEGACY];

  // Register selects shared by the write path
  assign sel_ctrl = paddr == `ILC_OFF_CTRL;
  assign sel_func = paddr == `ILC_OFF_FUNC;
  assign sel_behav = paddr == `ILC_OFF_BEHAV;

  // Behaviour fields that act at once; combine-disable waits for an apply write
  assign str_cfg = behav_q[`ILC_BEH_STR_LSB +: 2];
  assign rate_cfg = {behav_q[`ILC_BEH_RATE_B_LSB +: 2], behav_q[`ILC_BEH_RATE_A_LSB +: 2]};
  assign pulsing_en = behav_q[`ILC_BEH_PULSING];

  // Live status; the pin bits show the registered levels, not the decode
  assign status_word = {16'h0, aneg_fault, collision, tx_activity, rx_activity,
                        full_duplex, link_speed, link_up, 2'h0,
                        indicator_out_b, indicator_out_a, strap_lat_q, legacy, 2'h0};

  // One wait state: pready and read data rise together, both registered
  // A master that drops psel early simply gets no answer; nothing is left pending
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= !hit;
      prdata <= pwrite ? 32'h00000000 : rd_d;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Address decode and read mux; unmapped addresses read zero with an error
  always @* begin
    hit = 1'b1;
    rd_d = 32'h00000000;
    case (paddr)
      `ILC_OFF_CTRL: rd_d = {29'h0, ctrl_q};
      `ILC_OFF_FUNC: rd_d = {24'h0, func_q};
      `ILC_OFF_BEHAV: rd_d = {16'h0, behav_q};
      `ILC_OFF_STAT: rd_d = status_word;
      default: hit = 1'b0;
    endcase
  end

  // Software-written registers
  // Writes to the status word or unmapped offsets change nothing
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `ILC_CTRL_RST;
      func_q <= `ILC_FUNC_RST;
      behav_q <= `ILC_BEH_RST;
      cdis_eff_q <= 2'h0;
    end else if (wr_en) begin
      if (sel_ctrl) begin
        ctrl_q <= pwdata[2:0];
      end
      if (sel_func) begin
        func_q <= pwdata[7:0];
      end
      if (sel_behav) begin
        behav_q <= pwdata[15:0];
        if (pwdata[`ILC_BEH_APPLY]) begin
          cdis_eff_q <= pwdata[`ILC_BEH_CDIS_LSB +: 2];
        end
      end
    end
  end

  // Strap passes two flip-flops, then is caught once, at the third edge after release
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_m_q <= 1'b0;
      strap_s_q <= 1'b0;
      lat_age_q <= 2'h0;
      strap_lat_q <= 1'b0;
    end else begin
      strap_m_q <= style_strap;
      strap_s_q <= strap_m_q;
      // The second flop holds its reset value until the second edge after release
      if (lat_age_q != 2'h3) begin
        lat_age_q <= lat_age_q + 2'h1;
      end
      if (lat_age_q == 2'h2) begin
        strap_lat_q <= strap_s_q;
      end
    end
  end

  // Shaping timebase prescaler
  // A short tick period in simulation scales every shaping length alike
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= 24'h000000;
      tick_q <= 1'b0;
    end else if (tick_cnt_q >= TICK_CYCLES[23:0] - 24'h000001) begin
      tick_cnt_q <= 24'h000000;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 24'h000001;
      tick_q <= 1'b0;
    end
  end

  // Power-saving modulation carrier
  // Free running, so the carrier phase bears no relation to any event
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_cnt_q <= 12'h000;
      pulse_on_q <= 1'b0;
    end else begin
      if (pulse_cnt_q >= PULSE_CYCLES - 12'h001) begin
        pulse_cnt_q <= 12'h000;
      end else begin
        pulse_cnt_q <= pulse_cnt_q + 12'h001;
      end
      pulse_on_q <= pulse_cnt_q < PULSE_ON_CYCLES;
    end
  end

  // Per-output function evaluation
  // Codes that are not link codes never match a link here
  function link_match;
    input [3:0] fn;
    input up;
    input [1:0] spd;
    reg s10;
    reg s100;
    reg s1000;
    begin
      s10 = spd == `ILC_SPD_10;
      s100 = spd == `ILC_SPD_100;
      s1000 = spd == `ILC_SPD_1000;
      case (fn)
        `ILC_FN_LINK_ANY: link_match = up;
        `ILC_FN_LINK_1000: link_match = up && s1000;
        `ILC_FN_LINK_100: link_match = up && s100;
        `ILC_FN_LINK_10: link_match = up && s10;
        `ILC_FN_LINK_100_1000: link_match = up && (s100 || s1000);
        `ILC_FN_LINK_10_1000: link_match = up && (s10 || s1000);
        `ILC_FN_LINK_10_100: link_match = up && (s10 || s100);
        default: link_match = 1'b0;
      endcase
    end
  endfunction

  wire any_act = rx_activity || tx_activity;
  wire link_1000 = link_up && link_speed == `ILC_SPD_1000;
  wire link_100 = link_up && link_speed == `ILC_SPD_100;
  wire link_10 = link_up && link_speed == `ILC_SPD_10;

  // Indication logic, on_d high means the LED is lit
  always @* begin : ind_logic
    integer i;
    reg [3:0] fn;
    reg comb;
    reg lm;
    i = 0;
    on_d = 2'h0;
    ev = 2'h0;
    fn = 4'h0;
    comb = 1'b0;
    lm = 1'b0;
    str_en = str_cfg;
    rate_sel = rate_cfg;
    if (legacy) begin
      // Both outputs share blink settings so they toggle in step
      str_en = 2'h0;
      rate_sel = {2{rate_cfg[1:0]}};
      // Strap high: output b shows the link, output a blinks with traffic
      if (strap_lat_q) begin
        on_d[1] = link_up;
        ev[0] = any_act;
        on_d[0] = shaped[0];
      end else begin
        // Tri-colour: the colour lit for the speed blinks while traffic flows
        ev = {2{any_act && link_up}};
        on_d[1] = (link_1000 || link_10) && !shaped[1];
        on_d[0] = (link_100 || link_10) && !shaped[0];
      end
      if (ctrl_q[`ILC_CTRL_ISO]) begin
        on_d = 2'h0;
      end
    end else begin
      // Enhanced: each output decodes its own four-bit function
      for (i = 0; i < 2; i = i + 1) begin
        fn = func_q[4 * i +: 4];
        comb = !cdis_eff_q[i];
        lm = link_match(fn, link_up, link_speed);
        case (fn)
          `ILC_FN_LINK_ANY, `ILC_FN_LINK_1000, `ILC_FN_LINK_100, `ILC_FN_LINK_10,
          `ILC_FN_LINK_100_1000, `ILC_FN_LINK_10_1000, `ILC_FN_LINK_10_100: begin
            ev[i] = lm && any_act;
            on_d[i] = lm && !(comb && shaped[i]);
          end
          `ILC_FN_DUPLEX: begin
            ev[i] = link_up && !full_duplex && collision;
            on_d[i] = (link_up && full_duplex) || (comb && shaped[i]);
          end
          `ILC_FN_COLLISION: begin
            ev[i] = collision;
            on_d[i] = shaped[i];
          end
          `ILC_FN_ACTIVITY: begin
            ev[i] = behav_q[`ILC_BEH_TXONLY] ? tx_activity : any_act;
            on_d[i] = shaped[i];
          end
          `ILC_FN_ANEG_FAULT: on_d[i] = aneg_fault;
          `ILC_FN_FORCE_OFF: on_d[i] = 1'b0;
          `ILC_FN_FORCE_ON: on_d[i] = 1'b1;
          default: on_d[i] = 1'b0;
        endcase
      end
    end
    if (ctrl_q[`ILC_CTRL_PDN]) begin
      on_d = 2'h0;
    end
    // Pulsing only thins what is still lit after every force-off
    if (pulsing_en) begin
      on_d = on_d & {2{pulse_on_q}};
    end
  end

  // One shaper per output
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : gen_shape
      ilc_shaper u_shaper (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick_q),
        .stretch_en(str_en[g]),
        .rate(rate_sel[2 * g +: 2]),
        .event_in(ev[g]),
        .shaped(shaped[g])
      );
    end
  endgenerate

  // Pins are active low; registering keeps decode glitches off them
  // The cost is one clock of lag between a status change and the pin
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      indicator_out_a <= 1'b1;
      indicator_out_b <= 1'b1;
    end else begin
      indicator_out_a <= !on_d[0];
      indicator_out_b <= !on_d[1];
    end
  end

endmodule

//--- ilc_shaper.v
`include "ilc_defines.vh"

// Turns event pulses into a blink or pulse-stretch indication
module ilc_shaper (
  input wire pclk,
  input wire presetn,
  input wire tick,
  input wire stretch_en,
  input wire [1:0] rate,
  input wire event_in,
  output reg shaped
);

  localparam ST_IDLE = 2'h0;
  localparam ST_ON = 2'h1;
  localparam ST_HOLD = 2'h2;

  // Lengths in ticks are worked out wide, then cut to the counter width on purpose
  localparam integer BLINK_HALF_I = `ILC_BLINK_HALF_MS / (`ILC_TICK_US / 1000);
  localparam integer STR_FULL_I = `ILC_STRETCH_MS / (`ILC_TICK_US / 1000);
  localparam [7:0] BLINK_HALF = BLINK_HALF_I[7:0];
  localparam [7:0] STR_FULL = STR_FULL_I[7:0];

  reg [1:0] state_q;
  reg [7:0] cnt_q;
  reg seen_q;
  reg [7:0] half_len;
  reg [7:0] on_len;

  // Length of one half period and of the first on phase, in ticks
  always @* begin
    if (stretch_en) begin
      on_len = STR_FULL << rate;
      half_len = (STR_FULL >> 1) << rate;
    end else begin
      half_len = BLINK_HALF >> rate;
      on_len = BLINK_HALF >> rate;
    end
  end

  // Counts in ticks, so a phase may run up to one tick short of its length
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      cnt_q <= 8'h00;
      seen_q <= 1'b0;
      shaped <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (event_in) begin
            state_q <= ST_ON;
            cnt_q <= on_len;
            seen_q <= 1'b0;
            shaped <= 1'b1;
          end
        end
        ST_ON: begin
          if (event_in) begin
            seen_q <= 1'b1;
          end
          if (tick) begin
            if (cnt_q > 8'h01) begin
              cnt_q <= cnt_q - 8'h01;
            end else if (stretch_en && (seen_q || event_in)) begin
              cnt_q <= half_len;
              seen_q <= 1'b0;
            end else begin
              state_q <= ST_HOLD;
              cnt_q <= half_len;
              shaped <= 1'b0;
            end
          end
        end
        ST_HOLD: begin
          // Events wait out the idle half period and are served afterwards
          if (event_in) begin
            seen_q <= 1'b1;
          end
          if (tick) begin
            if (cnt_q > 8'h01) begin
              cnt_q <= cnt_q - 8'h01;
            end else if (seen_q || event_in) begin
              state_q <= ST_ON;
              cnt_q <= on_len;
              seen_q <= 1'b0;
              shaped <= 1'b1;
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
          shaped <= 1'b0;
        end
      endcase
    end
  end

endmodule

//--- tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h0;
  reg link_up = 1'b0, full_duplex = 1'b0, rx_activity = 1'b0, tx_activity = 1'b0;
  reg collision = 1'b0, aneg_fault = 1'b0, style_strap = 1'b0, leg = 1'b1;
  reg [1:0] link_speed = 2'h0;
  wire [31:0] prdata;
  wire pready, pslverr, indicator_out_a, indicator_out_b;
  logic [32:0] exp_q[$];
  logic [32:0] m_val = 33'h0;
  logic m_rdy = 1'b0;
  int n_errors = 0, checked = 0, seed = 49464;
  logic [31:0] d;
  logic on;

  ilc_indicator_ctrl #(.TICK_CYCLES(10)) ilc_indicator_ctrl_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link_up(link_up),
    .link_speed(link_speed), .full_duplex(full_duplex), .rx_activity(rx_activity),
    .tx_activity(tx_activity), .collision(collision), .aneg_fault(aneg_fault),
    .style_strap(style_strap), .indicator_out_a(indicator_out_a), .indicator_out_b(indicator_out_b));

  always #50 pclk = ~pclk;

  task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Results arrive as read answers or finished pin measurements
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) check("read", {pslverr, prdata}, exp_q.pop_front());
    if (m_rdy) check("pin_a", m_val, exp_q.pop_front());
  end

  // Holds the request until pready is seen at an edge; no fixed latency assumed
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dt);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dt;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (!pready && n < 20);
    if (n >= 20) begin
      n_errors++;
      summarize();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  // Status word with the expected pin levels
  task automatic rd_pins(input logic b, input logic a);
    repeat (5) @(posedge pclk);
    rd(8'h0c, {17'h0, aneg_fault, collision, tx_activity, rx_activity, full_duplex, link_speed,
      link_up, 2'b00, b, a, style_strap, leg, 2'b00});
  endtask

  // One event, then count the cycles output a is low over a window
  task automatic ms(input logic [3:0] fn, input logic [15:0] bh, input logic [2:0] ev, input int lo,
    input int hi, input int w);
    int c;
    apb(1'b1, 8'h08, {16'h0, bh});
    apb(1'b1, 8'h04, {28'h0, fn});
    repeat (300) @(posedge pclk);
    {collision, rx_activity, tx_activity} <= ev;
    @(posedge pclk);
    {collision, rx_activity, tx_activity} <= 3'b000;
    c = 0;
    repeat (w) begin
      @(posedge pclk);
      c += (indicator_out_a === 1'b0);
    end
    exp_q.push_back(33'h1);
    m_val <= {32'h0, c >= lo && c <= hi};
    m_rdy <= 1'b1;
    @(posedge pclk);
    m_rdy <= 1'b0;
  endtask

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(8'h00, 33'h1);
    rd(8'h04, 33'h0);
    rd(8'h08, 33'h0);
    rd(8'h10, {1'b1, 32'h0});
    d = $random(seed);
    apb(1'b1, 8'h04, {24'h0, d[7:0]});
    rd(8'h04, {25'h0, d[7:0]});
    $display("test registers done");
    // Tri-colour: index 3 is no link
    for (int i = 0; i < 4; i++) begin
      link_up <= (i < 3);
      link_speed <= (i < 3) ? i[1:0] : 2'h0;
      @(posedge pclk);
      rd_pins(i == 3 || i == 1, i == 3 || i == 2);
    end
    link_up <= 1'b1;
    apb(1'b1, 8'h00, 32'h3);
    rd_pins(1'b1, 1'b1);
    apb(1'b1, 8'h00, 32'h5);
    rd_pins(1'b1, 1'b1);
    $display("test tri-colour done");
    leg <= 1'b0;
    apb(1'b1, 8'h00, 32'h0);
    aneg_fault <= 1'b1;
    full_duplex <= 1'b1;
    for (int s = 0; s < 3; s++) begin
      for (int c = 0; c < 16; c++) begin
        link_speed <= s[1:0];
        apb(1'b1, 8'h04, {24'h0, c[3:0], c[3:0]});
        on = (c < 7) ? 48'h0033_0055_0069 >> (s * 16 + c) : 16'h9100 >> c;
        rd_pins(!on, !on);
      end
    end
    $display("test function codes done");
    ms(4'ha, 16'h0030, 3'b001, 40, 50, 150);
    ms(4'ha, 16'h0030, 3'b010, 40, 50, 150);
    ms(4'ha, 16'h0130, 3'b010, 0, 0, 150);
    ms(4'h9, 16'h0004, 3'b100, 90, 100, 150);
    ms(4'h0, 16'h0030, 3'b001, 100, 110, 150);
    ms(4'h0, 16'h8031, 3'b001, 150, 150, 150);
    ms(4'hf, 16'h1000, 3'b000, 400, 400, 2000);
    $display("test shaping done");
    // A second reset with the strap high selects the individual style
    style_strap <= 1'b1;
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    leg <= 1'b1;
    rd_pins(1'b0, 1'b1);
    $display("test strap done");
    summarize();
  end
endmodule
